// >>> hw/dbc_pkg.sv
// Purpose: Shared constants and carrier types for the debug comparators.
// Assumes: AHB-Lite register bus, 32-bit data, one word per register.
// Notes:   Register offsets are byte addresses.
package dbc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_A_EXT    = 8'h00; // Comparator A extended
  localparam logic [7:0] OFS_A_HI     = 8'h04; // Comparator A high byte
  localparam logic [7:0] OFS_A_LO     = 8'h08; // Comparator A low byte
  localparam logic [7:0] OFS_B_EXT    = 8'h0C; // Comparator B extended
  localparam logic [7:0] OFS_B_HI     = 8'h10; // Comparator B high byte
  localparam logic [7:0] OFS_B_LO     = 8'h14; // Comparator B low byte
  localparam logic [7:0] OFS_CTRL_ONE = 8'h18; // Control one
  localparam logic [7:0] OFS_CTRL_TWO = 8'h1C; // Control two
  localparam logic [7:0] OFS_MASKS    = 8'h20; // Mask settings
  localparam logic [7:0] OFS_STATUS   = 8'h24; // Sticky events (RO)
  localparam logic [7:0] OFS_CLEAR    = 8'h28; // Event clear (WO)
  localparam logic [7:0] OFS_IRQ_EN   = 8'h2C; // Event enable
  localparam logic [7:0] OFS_MODE     = 8'h30; // Active mode (RO)
  // ==========================================================
  // Field positions
  localparam int POS_PAGE_SELECTOR_LSB = 6;  // Page selector low bit
  localparam int POS_DBG_EN     = 7;  // Debug enable in control one
  localparam int POS_BKP_EN     = 7;  // Breakpoint enable in control two
  localparam int POS_PP_A_MSK   = 0;  // Mask bits [3:2]=A hi:lo, [1:0]=B
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_EVT  = 2'h0;

  typedef enum logic [1:0] {DBC_OFF, DBC_LEGACY, DBC_DEBUG} dbc_mode_t;

  // Core bus sample for one cycle
  typedef struct packed {
    logic        valid;     // Bus cycle in progress
    logic [15:0] addr;      // Core address bus
    logic [15:0] data;      // Data bus
    logic [5:0]  program_page_signal;     // Program page of the access
    logic        flash;     // Access in flash/ROM space
    logic [1:0]  xab_hi;    // Expanded address bits 15:14
  } dbc_bus_t;

  typedef struct packed {
    logic [7:0] a_ext, a_hi, a_lo, b_ext, b_hi, b_lo;
    logic [7:0] ctrl1, ctrl2, masks;
    logic [1:0] status, irq_en;
    logic       mark_a, mark_b;     // Comparator outputs
    logic       irq;
    logic       secure_m, secure_s; // Secure pin synchroniser
    logic       hsel_d, hwr_d;      // Data phase capture
    logic [7:0] haddr_d;
    logic [31:0] rdata;
  } dbc_state_t;
endpackage

// >>> hw/dbc_comparators.sv
// Purpose: Debug comparators A and B with AHB-Lite register access.
// Assumes: Core bus arrives on clk; secure level is asynchronous.
// Notes:   Matches are registered, one cycle behind the bus sample.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
// ==========================================================
// Behaviour and limits
// - Both comparators sample the core bus every cycle; a match is
//   reported one clock after the sample, never combinationally, so
//   the match pins can leave the block straight from flip-flops.
// - Read/write qualification and tagging are not handled here; a
//   match means only that the compared address or data bits agree.
// - Only the program page is carried by the core bus sample, so
//   page selector codes fold by bit 6 alone onto code 00 (no page) or
//   the program page code 01 (bit 7 of the selector is never looked at).
// - The secure level is asynchronous and passes two flip-flops;
//   debug mode can therefore stay up for two clocks after it rises.
// - Status bits are sticky: a match in the same cycle as a clear
//   write keeps its bit set, so no event is lost to a late clear.
// Function
// R1: Mask 0:1 ignores low address byte
// R2: Mask 1:1 ignores high and low bytes
// R3: Page compare only for program page
// R4: Full mode B data mask decode
// R5: Full mode ignores B extended register
// R6: Page selector MSB ignored, debug only
// R7: Legacy: extended bits vs 19:14 on flash
// R8: Legacy flash high bits 5:0 only
// R9: Debug page 01 uses expanded address
// R10: A value bits set address polarity
// R11: B compares data bus in full mode
// R12: Extended bits compared with core page
// R13: Enables select legacy or debug mode
// R14: Breakpoint enable wins over debug enable
// R15: Secure operation blocks debug mode
// R16: Page selector resets to 00
// R17: Match only when every compared bit equal
module dbc_comparators
  import dbc_pkg::*;
(
  input  wire logic        clk,        // 200 MHz core clock
  input  wire logic        rst,        // Async reset, active high
  input  wire logic        hsel,       // Slave select
  input  wire logic [31:0] haddr,      // Byte address
  input  wire logic [1:0]  htrans,     // Transfer type
  input  wire logic        hwrite,     // Write strobe
  input  wire logic [2:0]  hsize,      // Word transfers only
  input  wire logic [31:0] hwdata,     // Write data
  input  wire logic        hready,     // Bus ready
  output logic      [31:0] hrdata,     // Read data
  output logic             hreadyout,  // Always ready
  output logic             hresp,      // Always OKAY
  input  wire dbc_bus_t    bus,        // Core bus sample
  input  wire logic        full_mode,  // Full data breakpoint mode
  input  wire logic        secure,     // Chip is secured (async)
  output logic             match_a,    // Comparator A match
  output logic             match_b,    // Comparator B match
  output logic             irq         // Enabled event pending
);
  dbc_state_t r_reg, r_next;
  dbc_mode_t  mode;

  // ==========================================================
  // Compare helper
  // Compares one byte under a mask; masked bits always agree
  function automatic logic byte_eq(input logic [7:0] v, input logic [7:0] b,
                                   input logic [7:0] m);
    byte_eq = ((v ^ b) & m) == 8'h00;
  endfunction

  // One address comparator; modes share the mask decode and the low-byte compare
  function automatic logic addr_match(
      input logic [7:0] ext, input logic [7:0] hi, input logic [7:0] lo,
      input logic [1:0] msk, input dbc_mode_t md, input dbc_bus_t b);
    logic ext_ok, hi_ok, lo_ok, use_hi, use_lo;
    ext_ok = 1'b1;
    use_lo = ~msk[0];                         // [R1] [R3]
    use_hi = ~(msk[1] & msk[0]);              // [R2]
    hi_ok  = 1'b1;
    if (md == DBC_LEGACY) begin
      // Page selector has no effect here
      if (b.flash) begin
        ext_ok = (ext[5:0] == b.program_page_signal);       // [R7] [R12]
        hi_ok  = byte_eq(hi, {2'b00, b.addr[13:8]}, 8'h3F); // [R8]
      end else begin
        hi_ok  = (hi == b.addr[15:8]);        // [R8]
      end
    end else if (ext[POS_PAGE_SELECTOR_LSB]) begin   // [R6] bit 7 ignored
      ext_ok = (ext[5:0] == b.program_page_signal);         // [R9] [R12] [R3]
      hi_ok  = (hi == {b.xab_hi, b.addr[13:8]}); // [R9]
    end else begin
      hi_ok  = (hi == b.addr[15:8]);
    end
    lo_ok = (lo == b.addr[7:0]);              // [R10]
    addr_match = b.valid & ext_ok & (hi_ok | ~use_hi)
               & (lo_ok | ~use_lo);           // [R17]
  endfunction

  // ==========================================================
  // Mode selection
  always_comb begin
    if (r_reg.ctrl2[POS_BKP_EN])
      mode = DBC_LEGACY;                      // [R13] [R14]
    else if (r_reg.ctrl1[POS_DBG_EN] && !r_reg.secure_s)
      mode = DBC_DEBUG;                       // [R13] [R15]
    else
      mode = DBC_OFF;
  end

  // ==========================================================
  // Next state
  always_comb begin
    logic       ma, mb, full_b;
    logic [1:0] evt, clr;
    r_next = r_reg;
    ma = 1'b0;
    mb = 1'b0;
    clr = 2'b00;
    full_b = full_mode && (mode == DBC_DEBUG);
    // Secure level passes two flops before use
    r_next.secure_m = secure;
    r_next.secure_s = r_reg.secure_m;
    if (mode != DBC_OFF) begin
      ma = addr_match(r_reg.a_ext, r_reg.a_hi, r_reg.a_lo,
                      r_reg.masks[3:2], mode, bus);
      if (full_b)
        // Extended register unused in full mode
        mb = bus.valid                                    // [R5]
           & (byte_eq(r_reg.b_hi, bus.data[15:8],
                      {8{~r_reg.masks[1]}}))              // [R4] [R11]
           & (byte_eq(r_reg.b_lo, bus.data[7:0],
                      {8{~r_reg.masks[0]}}));             // [R4] [R17]
      else
        mb = addr_match(r_reg.b_ext, r_reg.b_hi, r_reg.b_lo,
                        r_reg.masks[1:0], mode, bus);     // [R11]
    end
    r_next.mark_a = ma;
    r_next.mark_b = mb;
    evt = {mb, ma};
    // Bus data phase
    r_next.hsel_d = hsel && htrans[1] && hready;
    r_next.hwr_d  = hwrite;
    r_next.haddr_d = haddr[7:0];
    if (r_reg.hsel_d && r_reg.hwr_d) begin
      if (r_reg.haddr_d == OFS_A_EXT) r_next.a_ext = hwdata[7:0];
      else if (r_reg.haddr_d == OFS_A_HI) r_next.a_hi = hwdata[7:0];
      else if (r_reg.haddr_d == OFS_A_LO) r_next.a_lo = hwdata[7:0];
      else if (r_reg.haddr_d == OFS_B_EXT) r_next.b_ext = hwdata[7:0];
      else if (r_reg.haddr_d == OFS_B_HI) r_next.b_hi = hwdata[7:0];
      else if (r_reg.haddr_d == OFS_B_LO) r_next.b_lo = hwdata[7:0];
      else if (r_reg.haddr_d == OFS_CTRL_ONE) r_next.ctrl1 = hwdata[7:0];
      else if (r_reg.haddr_d == OFS_CTRL_TWO) r_next.ctrl2 = hwdata[7:0];
      else if (r_reg.haddr_d == OFS_MASKS) r_next.masks = hwdata[7:0];
      else if (r_reg.haddr_d == OFS_CLEAR) clr = hwdata[1:0];
      else if (r_reg.haddr_d == OFS_IRQ_EN) r_next.irq_en = hwdata[1:0];
    end
    // Set wins over clear so no event is lost
    r_next.status = (r_reg.status & ~clr) | evt;
    r_next.irq = |(r_next.status & r_next.irq_en);
    // Read data registered for the next data phase
    r_next.rdata = 32'h0000_0000;
    if (hsel && htrans[1] && hready && !hwrite) begin
      if (haddr[7:0] == OFS_A_EXT) r_next.rdata[7:0] = r_next.a_ext;
      else if (haddr[7:0] == OFS_A_HI) r_next.rdata[7:0] = r_next.a_hi;
      else if (haddr[7:0] == OFS_A_LO) r_next.rdata[7:0] = r_next.a_lo;
      else if (haddr[7:0] == OFS_B_EXT) r_next.rdata[7:0] = r_next.b_ext;
      else if (haddr[7:0] == OFS_B_HI) r_next.rdata[7:0] = r_next.b_hi;
      else if (haddr[7:0] == OFS_B_LO) r_next.rdata[7:0] = r_next.b_lo;
      else if (haddr[7:0] == OFS_CTRL_ONE)
        r_next.rdata[7:0] = r_next.ctrl1;
      else if (haddr[7:0] == OFS_CTRL_TWO)
        r_next.rdata[7:0] = r_next.ctrl2;
      else if (haddr[7:0] == OFS_MASKS) r_next.rdata[7:0] = r_next.masks;
      else if (haddr[7:0] == OFS_STATUS)
        r_next.rdata[1:0] = r_next.status;
      else if (haddr[7:0] == OFS_IRQ_EN)
        r_next.rdata[1:0] = r_next.irq_en;
      else if (haddr[7:0] == OFS_MODE)
        r_next.rdata[1:0] = mode;
    end
  end

  // ==========================================================
  // State register; everything resets to zero incl. page selector
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;                            // [R16]
    end else begin
      r_reg <= r_next;
    end
  end

  assign hrdata    = r_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign match_a   = r_reg.mark_a;
  assign match_b   = r_reg.mark_b;
  assign irq       = r_reg.irq;

  // ==========================================================
  // Checks
  a_bkp_priority: assert property (@(posedge clk) disable iff (rst) // [R14]
    r_reg.ctrl2[POS_BKP_EN] |-> mode == DBC_LEGACY)
    else $error("breakpoint enable lost priority");
  a_secure_block: assert property (@(posedge clk) disable iff (rst) // [R15]
    r_reg.secure_s |-> mode != DBC_DEBUG)
    else $error("debug mode entered while secure");
  a_off_nomatch: assert property (@(posedge clk) disable iff (rst) // [R13]
    mode == DBC_OFF |=> !match_a && !match_b)
    else $error("match while no mode active");
  a_full_nocmp: assert property (@(posedge clk) disable iff (rst) // [R4]
    (mode == DBC_DEBUG && full_mode && r_reg.masks[1:0] == 2'b11
     && bus.valid) |=> match_b)
    else $error("full mode no-compare did not match");
  a_a_exact: assert property (@(posedge clk) disable iff (rst) // [R17]
    (mode == DBC_DEBUG && !r_reg.a_ext[POS_PAGE_SELECTOR_LSB] && bus.valid
     && r_reg.masks[3:2] == 2'b00
     && {r_reg.a_hi, r_reg.a_lo} != bus.addr) |=> !match_a)
    else $error("A matched a different address");
  a_a_window: assert property (@(posedge clk) disable iff (rst) // [R1]
    (mode == DBC_DEBUG && !r_reg.a_ext[POS_PAGE_SELECTOR_LSB] && bus.valid
     && r_reg.masks[3:2] == 2'b01 && r_reg.a_hi == bus.addr[15:8])
    |=> match_a)
    else $error("A missed 256-byte window");
  a_a_page: assert property (@(posedge clk) disable iff (rst) // [R2]
    (mode == DBC_DEBUG && r_reg.a_ext[POS_PAGE_SELECTOR_LSB] && bus.valid
     && r_reg.masks[3:2] == 2'b11 && r_reg.a_ext[5:0] == bus.program_page_signal)
    |=> match_a)
    else $error("A missed page window");
  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    irq == |(r_reg.status & r_reg.irq_en))
    else $error("interrupt not tied to status");

  // ==========================================================
  // Mode checks
  // Debug mode only while its enable bit is set
  a_debug_needs_en: assert property (@(posedge clk) disable iff (rst) // [R13]
    mode == DBC_DEBUG |-> r_reg.ctrl1[POS_DBG_EN])
    else $error("debug mode without its enable");

  // Legacy mode only while the breakpoint enable is set
  a_legacy_needs_en: assert property (@(posedge clk) disable iff (rst) // [R13]
    mode == DBC_LEGACY |-> r_reg.ctrl2[POS_BKP_EN])
    else $error("legacy mode without its enable");

  // Neither enable set leaves the comparators idle
  a_off_no_en: assert property (@(posedge clk) disable iff (rst) // [R13]
    (!r_reg.ctrl1[POS_DBG_EN] && !r_reg.ctrl2[POS_BKP_EN])
    |-> mode == DBC_OFF)
    else $error("mode active with both enables clear");

  // Second flop of the secure synchroniser follows the first
  a_secure_sync: assert property (@(posedge clk) disable iff (rst) // [R15]
    r_reg.secure_s == $past(r_reg.secure_m))
    else $error("secure synchroniser skipped a stage");

  // ==========================================================
  // Legacy mode address checks
  // Flash access with a different page never matches
  a_a_legacy_ext: assert property (@(posedge clk) disable iff (rst) // [R7]
    (mode == DBC_LEGACY && bus.valid && bus.flash
     && r_reg.a_ext[5:0] != bus.program_page_signal) |=> !match_a)
    else $error("A matched a foreign flash page");

  // Flash access compares only six high bits and the page
  a_a_legacy_flash: assert property (@(posedge clk) disable iff (rst) // [R8]
    (mode == DBC_LEGACY && bus.valid && bus.flash
     && r_reg.masks[3:2] == 2'b00 && r_reg.a_ext[5:0] == bus.program_page_signal
     && r_reg.a_hi[5:0] == bus.addr[13:8]
     && r_reg.a_lo == bus.addr[7:0]) |=> match_a)
    else $error("A missed a flash address");

  // Other accesses use all eight high bits
  a_a_legacy_hi: assert property (@(posedge clk) disable iff (rst) // [R8]
    (mode == DBC_LEGACY && bus.valid && !bus.flash
     && r_reg.masks[3:2] != 2'b11
     && r_reg.a_hi != bus.addr[15:8]) |=> !match_a)
    else $error("A ignored the high address byte");

  // Low byte masked: any address in the 256-byte window
  a_a_legacy_win: assert property (@(posedge clk) disable iff (rst) // [R1]
    (mode == DBC_LEGACY && bus.valid && !bus.flash
     && r_reg.masks[3:2] == 2'b01
     && r_reg.a_hi == bus.addr[15:8]) |=> match_a)
    else $error("A missed its legacy window");

  // Both bytes masked outside flash: every access matches
  a_a_legacy_any: assert property (@(posedge clk) disable iff (rst) // [R2]
    (mode == DBC_LEGACY && bus.valid && !bus.flash
     && r_reg.masks[3:2] == 2'b11) |=> match_a)
    else $error("A missed with both bytes masked");

  // Same for comparator B in address mode
  a_b_legacy_any: assert property (@(posedge clk) disable iff (rst) // [R2]
    (mode == DBC_LEGACY && bus.valid && !bus.flash
     && r_reg.masks[1:0] == 2'b11) |=> match_b)
    else $error("B missed with both bytes masked");

  // A low byte that differs under a full compare never matches
  a_b_bit_pol: assert property (@(posedge clk) disable iff (rst) // [R10]
    (mode != DBC_OFF && !full_mode && bus.valid
     && r_reg.masks[1:0] == 2'b00
     && r_reg.b_lo != bus.addr[7:0]) |=> !match_b)
    else $error("B matched a different low byte");

  // ==========================================================
  // Debug mode address checks
  // Selector code 00 needs no page: both bytes masked match
  a_a_nopage: assert property (@(posedge clk) disable iff (rst) // [R3]
    (mode == DBC_DEBUG && !r_reg.a_ext[POS_PAGE_SELECTOR_LSB] && bus.valid
     && r_reg.masks[3:2] == 2'b11) |=> match_a)
    else $error("A used the page without selector");

  // Program page selected: a different page never matches
  a_a_page_diff: assert property (@(posedge clk) disable iff (rst) // [R12]
    (mode == DBC_DEBUG && r_reg.a_ext[POS_PAGE_SELECTOR_LSB] && bus.valid
     && r_reg.a_ext[5:0] != bus.program_page_signal) |=> !match_a)
    else $error("A matched a different page");

  // Expanded high bits take part in the high-byte compare
  a_a_debug_page: assert property (@(posedge clk) disable iff (rst) // [R9]
    (mode == DBC_DEBUG && r_reg.a_ext[POS_PAGE_SELECTOR_LSB] && bus.valid
     && r_reg.masks[3:2] == 2'b00 && r_reg.a_ext[5:0] == bus.program_page_signal
     && r_reg.a_hi == {bus.xab_hi, bus.addr[13:8]}
     && r_reg.a_lo == bus.addr[7:0]) |=> match_a)
    else $error("A missed an expanded address");

  // ==========================================================
  // Full mode data checks
  // Equal data matches whatever the B extended register holds
  a_b_data_full: assert property (@(posedge clk) disable iff (rst) // [R4] [R5]
    (mode == DBC_DEBUG && full_mode && bus.valid
     && r_reg.masks[1:0] == 2'b00
     && bus.data == {r_reg.b_hi, r_reg.b_lo}) |=> match_b)
    else $error("B missed equal data");

  // Different data under a full compare never matches
  a_b_data_diff: assert property (@(posedge clk) disable iff (rst) // [R11]
    (mode == DBC_DEBUG && full_mode && r_reg.masks[1:0] == 2'b00
     && bus.data != {r_reg.b_hi, r_reg.b_lo}) |=> !match_b)
    else $error("B matched different data");

  // Mask 0:1 looks at the high data byte only
  a_b_high_only: assert property (@(posedge clk) disable iff (rst) // [R4]
    (mode == DBC_DEBUG && full_mode && bus.valid
     && r_reg.masks[1:0] == 2'b01
     && bus.data[15:8] == r_reg.b_hi) |=> match_b)
    else $error("B missed on the high data byte");

  // Mask 1:0 looks at the low data byte only
  a_b_low_only: assert property (@(posedge clk) disable iff (rst) // [R4]
    (mode == DBC_DEBUG && full_mode && bus.valid
     && r_reg.masks[1:0] == 2'b10
     && bus.data[7:0] == r_reg.b_lo) |=> match_b)
    else $error("B missed on the low data byte");

  // ==========================================================
  // Event and bus checks
  // No bus cycle, no match
  a_idle_nomatch: assert property (@(posedge clk) disable iff (rst) // [R17]
    !bus.valid |=> !match_a && !match_b)
    else $error("match without a bus cycle");

  // A match always leaves its sticky bit set, even under a clear
  a_evt_a_sticky: assert property (@(posedge clk) disable iff (rst)
    match_a |-> r_reg.status[0])
    else $error("A event lost");
  a_evt_b_sticky: assert property (@(posedge clk) disable iff (rst)
    match_b |-> r_reg.status[1])
    else $error("B event lost");

  // Zero wait states and OKAY responses only
  a_bus_okay: assert property (@(posedge clk) disable iff (rst)
    hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
endmodule

// >>> dv/dbc_core_model.sv
// Purpose: Core bus partner that offers one sample per call.
// Assumes: Caller enters right after a rising clock edge.
// Notes:   Idle cycles show inverted fields so stale values never match.
`timescale 1ns/1ps
module dbc_core_model
  import dbc_pkg::*;
(
  input  wire logic clk, // Core clock
  output dbc_bus_t  bus  // Sample seen by the comparators
);
  // ==========================================================
  // Bus driver
  initial bus = '0;
  // Gap idle cycles model a slow core; valid low while idle
  task automatic issue(input dbc_bus_t s, input int gap);
    repeat (gap) @(posedge clk) bus <= {1'b0, ~bus[40:0]};
    @(posedge clk) bus <= s; // Page of the access rides along
    @(posedge clk) bus <= {1'b0, ~s[40:0]};
  endtask
endmodule

// >>> dv/dbc_comparators_bench.sv
// Purpose: Self-checking bench for debug comparators A and B.
// Assumes: Samples come from dbc_core_model; hreadyout feeds hready.
// Notes:   Reset values first, then table rows, mode, interrupt and mid-run reset cases.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module dbc_comparators_bench
  import dbc_pkg::*;
;
  typedef struct packed {
    logic [1:0]  md; // 1 legacy, 2 debug, 3 debug with data compare
    logic [7:0]  x;  // Extended value, both comparators
    logic [15:0] v;  // Compare value, both comparators
    logic [3:0]  m;  // Mask register
    logic [15:0] ad; // Core address
    logic [15:0] dt; // Data bus
    logic [5:0]  pp; // Program page
    logic        fl; // Flash/ROM access
    logic [1:0]  e;  // Expected {match_a, match_b}
  } dbc_row_t;
  logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic        full_mode, secure, match_a, match_b, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  dbc_bus_t    bus;
  dbc_row_t    r;
  int          error_cnt = 0;
  int          tests_run = 0;
  // Expanded address bits 15:14 are always 11 in these samples
  dbc_row_t rows [18] = '{
    '{2'h1,8'h00,16'h1234,4'h0,16'h1234,16'h0000,6'h00,1'h0,2'h3},
    '{2'h1,8'h00,16'h1234,4'h4,16'h12FF,16'h0000,6'h00,1'h0,2'h2},
    '{2'h1,8'h00,16'h1234,4'hF,16'hABCD,16'h0000,6'h00,1'h0,2'h3},
    '{2'h1,8'h05,16'h1234,4'h0,16'hD234,16'h0000,6'h05,1'h1,2'h3},
    '{2'h1,8'h05,16'h1234,4'h0,16'hD234,16'h0000,6'h06,1'h1,2'h0},
    '{2'h1,8'h05,16'h1234,4'h0,16'hD234,16'h0000,6'h05,1'h0,2'h0},
    '{2'h2,8'h45,16'hD234,4'h0,16'h1234,16'h0000,6'h05,1'h0,2'h3},
    '{2'h2,8'hC5,16'hD234,4'h0,16'h1234,16'h0000,6'h05,1'h0,2'h3},
    '{2'h2,8'h45,16'hD234,4'h0,16'h1234,16'h0000,6'h06,1'h0,2'h0},
    '{2'h2,8'h85,16'h1234,4'h0,16'h1234,16'h0000,6'h09,1'h0,2'h3},
    '{2'h2,8'h45,16'hD234,4'hF,16'h0000,16'h0000,6'h06,1'h0,2'h0},
    '{2'h3,8'h45,16'h1234,4'h0,16'h1234,16'h1234,6'h09,1'h0,2'h1},
    '{2'h3,8'h00,16'h1234,4'h1,16'h1234,16'h12FF,6'h00,1'h0,2'h3},
    '{2'h3,8'h00,16'h1234,4'h2,16'h1234,16'hFF34,6'h00,1'h0,2'h3},
    '{2'h3,8'h00,16'h1234,4'h3,16'h1234,16'hABCD,6'h00,1'h0,2'h3},
    '{2'h2,8'h45,16'hD234,4'hF,16'h0000,16'h0000,6'h05,1'h0,2'h3},
    '{2'h2,8'h00,16'h1234,4'h4,16'h12FF,16'h0000,6'h00,1'h0,2'h2},
    '{2'h3,8'h00,16'h1234,4'h0,16'h1234,16'h1235,6'h00,1'h0,2'h2}
  };
  assign hready = hreadyout; // Single slave drives bus ready
  dbc_core_model i_dbc_core_model (.clk(clk), .bus(bus));
  dbc_comparators i_dbc_comparators (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bus(bus),
    .full_mode(full_mode), .secure(secure), .match_a(match_a),
    .match_b(match_b), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================================
  // Bus tasks; every wait is bounded so a stuck slave ends the run
  task automatic conclude();
    $display("checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic hs();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (n == 64) begin
      error_cnt++;
      conclude();
    end
  endtask
  // One single word transfer; read data is taken at the data phase edge
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    hs();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hs();
    rdat = hrdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    xf(1'b0, a, 32'h0000_0000);
    `CHK(rdat, x)
  endtask
  task automatic wirq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 16) begin
      @(posedge clk);
      n++;
    end
    `CHK(irq, v)
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    full_mode = 1'b0;
    secure = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a <= 'h34; a += 4) rc(8'(a), 32'h0000_0000);
    xf(1'b1, 8'h34, 32'hFFFF_FFFF);
    rc(8'h34, 32'h0000_0000);
    // Table rows: program both comparators alike, then offer a sample
    foreach (rows[i]) begin
      r = rows[i];
      full_mode <= &r.md;
      xf(1'b1, OFS_CTRL_ONE, {24'h00_0000, r.md[1], 7'h00});
      xf(1'b1, OFS_CTRL_TWO, {24'h00_0000, r.md == 2'h1, 7'h00});
      for (int k = 0; k < 2; k++) begin
        xf(1'b1, k ? OFS_B_EXT : OFS_A_EXT, {24'h00_0000, r.x});
        xf(1'b1, k ? OFS_B_HI : OFS_A_HI, {24'h00_0000, r.v[15:8]});
        xf(1'b1, k ? OFS_B_LO : OFS_A_LO, {24'h00_0000, r.v[7:0]});
      end
      xf(1'b1, OFS_MASKS, {28'h000_0000, r.m});
      i_dbc_core_model.issue('{1'b1, r.ad, r.dt, r.pp, r.fl, 2'h3}, i % 3);
      #1;
      `CHK({match_a, match_b}, r.e)
    end
    // Mode selection, precedence and secure lockout
    xf(1'b1, OFS_CTRL_TWO, 32'h0000_0000);
    xf(1'b1, OFS_CTRL_ONE, 32'h0000_0080);
    rc(OFS_MODE, {30'h0000_0000, DBC_DEBUG});
    xf(1'b1, OFS_CTRL_TWO, 32'h0000_0080);
    rc(OFS_MODE, {30'h0000_0000, DBC_LEGACY});
    xf(1'b1, OFS_CTRL_TWO, 32'h0000_0000);
    secure <= 1'b1;
    repeat (3) @(posedge clk);
    rc(OFS_MODE, {30'h0000_0000, DBC_OFF});
    secure <= 1'b0;
    // Sticky events: enable, clear one, mask the other
    rc(OFS_STATUS, 32'h0000_0003);
    xf(1'b1, OFS_IRQ_EN, 32'h0000_0001);
    wirq(1'b1);
    xf(1'b1, OFS_CLEAR, 32'h0000_0001);
    rc(OFS_STATUS, 32'h0000_0002);
    wirq(1'b0);
    xf(1'b1, OFS_IRQ_EN, 32'h0000_0002);
    wirq(1'b1);
    // Reset in mid-run drops the interrupt and the page selector
    xf(1'b1, OFS_A_EXT, 32'h0000_00C5);
    rst <= 1'b1;
    @(posedge clk);
    `CHK(irq, 1'b0)
    rst <= 1'b0;
    rc(OFS_A_EXT, 32'h0000_0000);
    rc(OFS_STATUS, 32'h0000_0000);
    xf(1'b1, OFS_IRQ_EN, 32'h0000_0000);
    wirq(1'b0);
    conclude();
  end
endmodule
